/* File: core/gpio_pkg.sv */
package gpio_pkg;

  // ------------------------------------------------------------
  // register indices (byte address on the bus is index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_PORT0_DIRECTION = 8'hb8;
  localparam logic [7:0] IDX_PORT1_DIRECTION = 8'hc1;
  localparam logic [7:0] IDX_PORT5_DIRECTION = 8'hc5;
  localparam logic [7:0] IDX_PORT0_DATA = 8'hd0;
  localparam logic [7:0] IDX_PORT1_DATA = 8'hd1;
  localparam logic [7:0] IDX_PORT5_DATA = 8'hd5;
  localparam logic [7:0] IDX_PORT0_PULLUP = 8'he0;
  localparam logic [7:0] IDX_PORT1_PULLUP = 8'he1;
  localparam logic [7:0] IDX_PORT5_PULLUP = 8'he5;
  localparam logic [7:0] IDX_PIN_OPEN_DRAIN_CTRL = 8'he9;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam logic [7:0] PORT0_MASK = 8'h01;
  localparam logic [7:0] PORT1_MASK = 8'h3f;
  localparam logic [7:0] PORT1_DRIVE_MASK = 8'h1f;
  localparam logic [7:0] PORT5_MASK = 8'hff;
  localparam logic [7:0] OPEN_DRAIN_MASK = 8'h01;
  localparam logic [7:0] INPUT_ONLY_FORCE = 8'h20;
  localparam int unsigned INPUT_ONLY_BIT = 5;
  localparam int unsigned OPEN_DRAIN_ENABLE_BIT = 0;
  localparam int unsigned DRIVE_PINS = 14;
  localparam int unsigned OPEN_DRAIN_PIN_INDEX = 1;
  localparam int unsigned SYNC_W = 16;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] OPEN_DRAIN_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  localparam int unsigned ADR_W = 12;
  localparam int unsigned DAT_W = 32;

endpackage

/* File: core/reg_access_if.sv */
`timescale 1ns/1ps
`default_nettype none

// one register access per bus cycle, from the bus front end to the register file
interface reg_access_if;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport front (
    output wr,
    output idx,
    output wdata,
    input rdata
  );

  modport regs (
    input wr,
    input idx,
    input wdata,
    output rdata
  );
endinterface

`default_nettype wire

/* File: core/wb_reg_front.sv */
`timescale 1ns/1ps
`default_nettype none

module wb_reg_front (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [gpio_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [gpio_pkg::DAT_W-1:0] wb_dat_in,
  output logic [gpio_pkg::DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // register side
  reg_access_if.front acc
);

  logic ack_r;
  logic [gpio_pkg::DAT_W-1:0] dat_r;
  logic req;
  logic in_range;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // a request is served once: the held request is ignored while ack stands
  assign req = wb_cyc_in & wb_stb_in & ~ack_r;
  assign in_range = (wb_adr_in[gpio_pkg::ADR_W-1:10] == 2'h0);
  assign acc.idx = wb_adr_in[9:2];
  assign acc.wdata = wb_dat_in[7:0];
  // only the low lane carries register data; out-of-range writes are dropped
  assign acc.wr = req & wb_we_in & wb_sel_in[0] & in_range;

  // ------------------------------------------------------------
  // answer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dat_r <= 32'h0000_0000;
    end else if (req) begin
      dat_r <= (!wb_we_in && in_range) ? {24'h00_0000, acc.rdata} : 32'h0000_0000;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;

endmodule

`default_nettype wire

/* File: core/gpio_ports.sv */
`timescale 1ns/1ps
`default_nettype none

module gpio_ports (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [gpio_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [gpio_pkg::DAT_W-1:0] wb_dat_in,
  output logic [gpio_pkg::DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // configuration option
  input wire logic ext_reset_en_in,
  // port 0 pins
  input wire logic port0_pin_in,
  output logic port0_pin_out,
  output logic port0_pin_oe_out,
  output logic port0_pullup_out,
  // port 1 pins (bit 5 is the reset-option input pin)
  input wire logic [5:0] port1_pin_in,
  output logic [4:0] port1_pin_out,
  output logic [4:0] port1_pin_oe_out,
  output logic [5:0] port1_pullup_out,
  // port 5 pins
  input wire logic [7:0] port5_pin_in,
  output logic [7:0] port5_pin_out,
  output logic [7:0] port5_pin_oe_out,
  output logic [7:0] port5_pullup_out
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------
  reg_access_if acc ();

  wb_reg_front u_front (
    .clk_in(clk_in),
    .rst_n_in(rst_n_r),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out),
    .acc(acc)
  );

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // pins and the option strap all come from outside the clock domain
  logic [gpio_pkg::SYNC_W-1:0] pin_meta_r;
  logic [gpio_pkg::SYNC_W-1:0] pin_sync_r;
  logic [gpio_pkg::SYNC_W-1:0] pin_raw;

  assign pin_raw = {ext_reset_en_in, port5_pin_in, port1_pin_in, port0_pin_in};

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= 16'h0000;
      pin_sync_r <= 16'h0000;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  logic [7:0] port0_level;
  logic [7:0] port1_level;
  logic [7:0] port5_level;
  logic ext_reset_en;

  assign ext_reset_en = pin_sync_r[15];
  assign port0_level = {7'h00, pin_sync_r[0]};
  assign port5_level = pin_sync_r[14:7];
  // the reset-option pin reads 1 while it serves as external reset
  assign port1_level = {2'h0, pin_sync_r[6] | ext_reset_en, pin_sync_r[5:1]};

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic wr_dir0;
  logic wr_dir1;
  logic wr_dir5;
  logic wr_dat0;
  logic wr_dat1;
  logic wr_dat5;
  logic wr_pu0;
  logic wr_pu1;
  logic wr_pu5;
  logic wr_od;

  assign wr_dir0 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT0_DIRECTION);
  assign wr_dir1 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT1_DIRECTION);
  assign wr_dir5 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT5_DIRECTION);
  assign wr_dat0 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT0_DATA);
  assign wr_dat1 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT1_DATA);
  assign wr_dat5 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT5_DATA);
  assign wr_pu0 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT0_PULLUP);
  assign wr_pu1 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT1_PULLUP);
  assign wr_pu5 = acc.wr && (acc.idx == gpio_pkg::IDX_PORT5_PULLUP);
  assign wr_od = acc.wr && (acc.idx == gpio_pkg::IDX_PIN_OPEN_DRAIN_CTRL);

  // ------------------------------------------------------------
  // direction registers
  // ------------------------------------------------------------
  logic [7:0] dir0_r;
  logic [7:0] dir1_r;
  logic [7:0] dir5_r;

  // a byte write replaces the register; single-bit changes are done by
  // read-modify-write, which works because every direction bit reads back
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dir0_r <= gpio_pkg::DIRECTION_RST;
      dir1_r <= gpio_pkg::DIRECTION_RST | gpio_pkg::INPUT_ONLY_FORCE;
      dir5_r <= gpio_pkg::DIRECTION_RST;
    end else begin
      if (wr_dir0) begin
        dir0_r <= acc.wdata & gpio_pkg::PORT0_MASK;
      end
      if (wr_dir1) begin
        dir1_r <= (acc.wdata & gpio_pkg::PORT1_DRIVE_MASK) | gpio_pkg::INPUT_ONLY_FORCE;
      end
      if (wr_dir5) begin
        dir5_r <= acc.wdata & gpio_pkg::PORT5_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // output latches
  // ------------------------------------------------------------
  logic [7:0] lat0_r;
  logic [7:0] lat1_r;
  logic [7:0] lat5_r;

  // the reset-option bit has no latch, so writes to it fall away
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lat0_r <= gpio_pkg::DATA_RST;
      lat1_r <= gpio_pkg::DATA_RST;
      lat5_r <= gpio_pkg::DATA_RST;
    end else begin
      if (wr_dat0) begin
        lat0_r <= acc.wdata & gpio_pkg::PORT0_MASK;
      end
      if (wr_dat1) begin
        lat1_r <= acc.wdata & gpio_pkg::PORT1_DRIVE_MASK;
      end
      if (wr_dat5) begin
        lat5_r <= acc.wdata & gpio_pkg::PORT5_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // pull-up and open-drain controls (write only)
  // ------------------------------------------------------------
  logic [7:0] pu0_r;
  logic [7:0] pu1_r;
  logic [7:0] pu5_r;
  logic [7:0] od_r;

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pu0_r <= gpio_pkg::PULLUP_RST;
      pu1_r <= gpio_pkg::PULLUP_RST | gpio_pkg::INPUT_ONLY_FORCE;
      pu5_r <= gpio_pkg::PULLUP_RST;
    end else begin
      if (wr_pu0) begin
        pu0_r <= acc.wdata & gpio_pkg::PORT0_MASK;
      end
      if (wr_pu1) begin
        pu1_r <= (acc.wdata & gpio_pkg::PORT1_DRIVE_MASK) | gpio_pkg::INPUT_ONLY_FORCE;
      end
      if (wr_pu5) begin
        pu5_r <= acc.wdata;
      end
    end
  end

  // whole-byte update only; bits above the enable are dropped
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      od_r <= gpio_pkg::OPEN_DRAIN_RST;
    end else if (wr_od) begin
      od_r <= acc.wdata & gpio_pkg::OPEN_DRAIN_MASK;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // pull-up and open-drain registers cannot be read back, so a
  // read-modify-write on them loses state: software must write whole bytes
  always_comb begin
    case (acc.idx)
      gpio_pkg::IDX_PORT0_DIRECTION: acc.rdata = dir0_r;
      gpio_pkg::IDX_PORT1_DIRECTION: acc.rdata = dir1_r;
      gpio_pkg::IDX_PORT5_DIRECTION: acc.rdata = dir5_r;
      gpio_pkg::IDX_PORT0_DATA: acc.rdata = port0_level;
      gpio_pkg::IDX_PORT1_DATA: acc.rdata = port1_level;
      gpio_pkg::IDX_PORT5_DATA: acc.rdata = port5_level;
      default: acc.rdata = gpio_pkg::READ_ZERO;
    endcase
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // drive vectors: bit 0 port 0, bits 5:1 port 1 pins 4:0, bits 13:6 port 5
  logic [gpio_pkg::DRIVE_PINS-1:0] dir_all;
  logic [gpio_pkg::DRIVE_PINS-1:0] lat_all;
  logic [gpio_pkg::DRIVE_PINS-1:0] oe_r;
  logic [gpio_pkg::DRIVE_PINS-1:0] out_r;
  logic od_en;

  assign dir_all = {dir5_r, dir1_r[4:0], dir0_r[0]};
  assign lat_all = {lat5_r, lat1_r[4:0], lat0_r[0]};
  assign od_en = od_r[gpio_pkg::OPEN_DRAIN_ENABLE_BIT];

  // registered so every pad signal leaves a flop; pads lag the
  // registers by one clock, which software cannot observe
  genvar gi;
  generate
    for (gi = 0; gi < gpio_pkg::DRIVE_PINS; gi++) begin : g_pin
      if (gi == gpio_pkg::OPEN_DRAIN_PIN_INDEX) begin : g_od
        // open drain relies on software having set the direction first
        always_ff @(posedge clk_in or negedge rst_n_r) begin
          if (!rst_n_r) begin
            oe_r[gi] <= 1'b0;
            out_r[gi] <= 1'b0;
          end else if (od_en) begin
            oe_r[gi] <= dir_all[gi] & ~lat_all[gi];
            out_r[gi] <= 1'b0;
          end else begin
            oe_r[gi] <= dir_all[gi];
            out_r[gi] <= lat_all[gi];
          end
        end
      end else begin : g_pp
        always_ff @(posedge clk_in or negedge rst_n_r) begin
          if (!rst_n_r) begin
            oe_r[gi] <= 1'b0;
            out_r[gi] <= 1'b0;
          end else begin
            oe_r[gi] <= dir_all[gi];
            out_r[gi] <= lat_all[gi];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // pad outputs
  // ------------------------------------------------------------
  assign port0_pin_out = out_r[0];
  assign port0_pin_oe_out = oe_r[0];
  assign port1_pin_out = out_r[5:1];
  assign port1_pin_oe_out = oe_r[5:1];
  assign port5_pin_out = out_r[13:6];
  assign port5_pin_oe_out = oe_r[13:6];
  assign port0_pullup_out = pu0_r[0];
  assign port1_pullup_out = pu1_r[5:0];
  assign port5_pullup_out = pu5_r;

endmodule

`default_nettype wire

/* File: verif/gpio_ports_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [gpio_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [gpio_pkg::DAT_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  // option and pins
  input wire logic ext_reset_en_in,
  input wire logic port0_pin_out,
  input wire logic port0_pin_oe_out,
  input wire logic [4:0] port1_pin_out,
  input wire logic [4:0] port1_pin_oe_out,
  input wire logic [5:0] port1_pullup_out,
  input wire logic [7:0] port5_pin_out,
  input wire logic [7:0] port5_pin_oe_out
);
  logic req;
  logic rd_req;
  logic [27:0] pins;
  logic [7:0] ridx;
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  // only in-range reads reach a register; the rest answer zero
  assign rd_req = req && !wb_we_in && (wb_adr_in[11:10] == 2'h0);
  assign ridx = wb_adr_in[9:2];
  assign pins = {port0_pin_oe_out, port1_pin_oe_out, port5_pin_oe_out,
                 port0_pin_out, port1_pin_out, port5_pin_out};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  ack_answer_a: assert property (req |=> wb_ack_out)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(req))
    else $error("ack without a request");
  upper_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  pullup_hold_a: assert property (port1_pullup_out[5])
    else $error("input-only pin pull-up bit not held");
  wo_zero_a: assert property (rd_req && (ridx == gpio_pkg::IDX_PORT0_PULLUP ||
    ridx == gpio_pkg::IDX_PORT1_PULLUP || ridx == gpio_pkg::IDX_PORT5_PULLUP ||
    ridx == gpio_pkg::IDX_PIN_OPEN_DRAIN_CTRL) |=> wb_dat_out[7:0] == 8'h00)
    else $error("write-only register read not zero");
  dir_force_a: assert property (rd_req && ridx == gpio_pkg::IDX_PORT1_DIRECTION |=>
    wb_dat_out[7:5] == 3'h1)
    else $error("port1 direction upper bits wrong");
  p0_mask_a: assert property (rd_req && ridx == gpio_pkg::IDX_PORT0_DIRECTION |=>
    wb_dat_out[7:1] == 7'h0)
    else $error("port0 direction unused bits not zero");
  ext_bit_a: assert property (ext_reset_en_in [*4] ##0 (rd_req &&
    ridx == gpio_pkg::IDX_PORT1_DATA) |=> wb_dat_out[5])
    else $error("reset-option data bit not one");
  pin_cause_a: assert property ($changed(pins) |-> $past(wb_ack_out && wb_we_in))
    else $error("pin drive changed without a write");

  cover property (req && wb_we_in);
  cover property (rd_req && ridx == gpio_pkg::IDX_PORT1_DATA);
  cover property (ext_reset_en_in [*4] ##0 (rd_req && ridx == gpio_pkg::IDX_PORT1_DATA));
endmodule

bind gpio_ports gpio_ports_checker i_gpio_ports_checker (
  .clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .ext_reset_en_in(ext_reset_en_in),
  .port0_pin_out(port0_pin_out), .port0_pin_oe_out(port0_pin_oe_out),
  .port1_pin_out(port1_pin_out), .port1_pin_oe_out(port1_pin_oe_out),
  .port1_pullup_out(port1_pullup_out), .port5_pin_out(port5_pin_out),
  .port5_pin_oe_out(port5_pin_oe_out)
);

`default_nettype wire

/* File: verif/pad_board.sv */
`timescale 1ns/1ps
`default_nettype none

// pads plus board: driven pins loop back, released pins take the outside drive or fall to a pull-up or wander
module pad_board #(
  parameter int N = 15,
  parameter logic [N-1:0] BOARD_PU = 15'h0002
) (
  input wire logic clk_in,
  input wire logic [N-1:0] out_in,
  input wire logic [N-1:0] oe_in,
  input wire logic [N-1:0] pu_in,
  input wire logic [N-1:0] ext_en_in,
  input wire logic [N-1:0] ext_val_in,
  output logic [N-1:0] level_out
);
  logic [N-1:0] wave_r = '0;
  logic [N-1:0] held;
  // a floating pin must not read as a stable value, so it toggles every cycle
  always_ff @(posedge clk_in) begin
    wave_r <= ~wave_r;
  end
  assign held = pu_in | BOARD_PU;
  assign level_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_val_in) |
                     (~oe_in & ~ext_en_in & (held | wave_r & ~held));
endmodule

`default_nettype wire

/* File: verif/gpio_ports_with_open_drain_test.sv */
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_with_open_drain_test;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} row_s;
  logic clk_in = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [gpio_pkg::ADR_W-1:0] adr = '0;
  logic [gpio_pkg::DAT_W-1:0] wdat = '0;
  logic ext_rst = 1'b1;
  logic [14:0] ext_en = '0;
  logic [14:0] ext_val = '0;
  logic [14:0] level;
  logic [gpio_pkg::DAT_W-1:0] dat_out;
  logic ack;
  logic p0_out, p0_oe, p0_pu;
  logic [4:0] p1_out, p1_oe;
  logic [5:0] p1_pu;
  logic [7:0] p5_out, p5_oe, p5_pu;
  logic [7:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  row_s rows [9] = '{
    '{gpio_pkg::IDX_PORT0_DIRECTION, 8'hff, 8'h01},
    '{gpio_pkg::IDX_PORT1_DIRECTION, 8'hff, 8'h3f},
    '{gpio_pkg::IDX_PORT1_DIRECTION, 8'h00, 8'h20},
    '{gpio_pkg::IDX_PORT5_DIRECTION, 8'ha5, 8'ha5},
    '{gpio_pkg::IDX_PORT0_PULLUP, 8'hff, 8'h00},
    '{gpio_pkg::IDX_PORT1_PULLUP, 8'hff, 8'h00},
    '{gpio_pkg::IDX_PORT5_PULLUP, 8'hff, 8'h00},
    '{gpio_pkg::IDX_PIN_OPEN_DRAIN_CTRL, 8'h00, 8'h00},
    '{8'hff, 8'h5a, 8'h00}};

  gpio_ports i_gpio_ports (
    .clk_in(clk_in), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(dat_out),
    .wb_ack_out(ack), .ext_reset_en_in(ext_rst), .port0_pin_in(level[0]),
    .port0_pin_out(p0_out), .port0_pin_oe_out(p0_oe), .port0_pullup_out(p0_pu),
    .port1_pin_in(level[6:1]), .port1_pin_out(p1_out), .port1_pin_oe_out(p1_oe),
    .port1_pullup_out(p1_pu), .port5_pin_in(level[14:7]), .port5_pin_out(p5_out),
    .port5_pin_oe_out(p5_oe), .port5_pullup_out(p5_pu)
  );

  // the reset-option pin has no pull-up resistor, whatever its held control bit says
  pad_board i_pad_board (
    .clk_in(clk_in), .out_in({p5_out, 1'b0, p1_out, p0_out}),
    .oe_in({p5_oe, 1'b0, p1_oe, p0_oe}), .pu_in({p5_pu, 1'b0, p1_pu[4:0], p0_pu}),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(level)
  );

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // bus, compare, closing and reset tasks
  // ------------------------------------------------------------
  // idle cycles first give spacing and let pin levels pass the synchronisers
  task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
    repeat (4) @(posedge clk_in);
    adr <= {2'h0, i, 2'h0};
    we <= w;
    wdat <= {24'h0, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_in); while (ack !== 1'b1);
    q = dat_out[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic reset_seq();
    nrst <= 1'b0;
    repeat (16) @(posedge clk_in);
    chk("pullup1_rst", 8'h20, {2'h0, p1_pu});
    chk("pullup5_rst", 8'h00, p5_pu);
    chk("oe5_rst", 8'h00, p5_oe);
    @(posedge clk_in);
    nrst <= 1'b1;
    bus(gpio_pkg::IDX_PORT1_DIRECTION, 1'b0, 8'h00);
    chk("dir1_rst", 8'h20, q);
  endtask

  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_seq();
    foreach (rows[k]) begin
      bus(rows[k].idx, 1'b1, rows[k].wd);
      bus(rows[k].idx, 1'b0, 8'h00);
      chk("row_read", rows[k].rd, q);
    end
    chk("pins_pu", 8'hff, p5_pu);
    chk("p1_pu", 8'h3f, {2'h0, p1_pu});
    chk("oe5", 8'ha5, p5_oe);
    chk("p0_pins", 8'h06, {5'h0, p0_pu, p0_oe, p0_out});
    bus(gpio_pkg::IDX_PORT1_PULLUP, 1'b1, 8'h00);
    chk("p1_pu_clr", 8'h20, {2'h0, p1_pu});
    // bit set then bit clear by read-modify-write
    bus(gpio_pkg::IDX_PORT5_DIRECTION, 1'b0, 8'h00);
    bus(gpio_pkg::IDX_PORT5_DIRECTION, 1'b1, q | 8'h10);
    chk("oe5_set", 8'hb5, p5_oe);
    bus(gpio_pkg::IDX_PORT5_DIRECTION, 1'b0, 8'h00);
    bus(gpio_pkg::IDX_PORT5_DIRECTION, 1'b1, q & 8'hfe);
    chk("oe5_clr", 8'hb4, p5_oe);
    bus(gpio_pkg::IDX_PORT5_DIRECTION, 1'b1, 8'hff);
    bus(gpio_pkg::IDX_PORT5_DATA, 1'b1, 8'h5a);
    chk("out5", 8'h5a, p5_out);
    bus(gpio_pkg::IDX_PORT5_DATA, 1'b0, 8'h00);
    chk("rd5_loop", 8'h5a, q);
    bus(gpio_pkg::IDX_PORT5_DIRECTION, 1'b1, 8'h00);
    ext_en <= 15'h7f80;
    ext_val <= 15'h6180;
    bus(gpio_pkg::IDX_PORT5_DATA, 1'b0, 8'h00);
    chk("rd5_ext", 8'hc3, q);
    ext_en <= 15'h0040;
    ext_val <= 15'h0000;
    // open drain only after the pin is an output
    bus(gpio_pkg::IDX_PORT1_DIRECTION, 1'b1, 8'h01);
    bus(gpio_pkg::IDX_PORT1_DATA, 1'b1, 8'h00);
    bus(gpio_pkg::IDX_PIN_OPEN_DRAIN_CTRL, 1'b1, 8'h01);
    chk("od_low", 8'h02, {6'h0, p1_oe[0], p1_out[0]});
    bus(gpio_pkg::IDX_PORT1_DATA, 1'b0, 8'h00);
    chk("od_low_rd", 8'h00, q & 8'h01);
    bus(gpio_pkg::IDX_PORT1_DATA, 1'b1, 8'h01);
    chk("od_high", 8'h00, {6'h0, p1_oe[0], p1_out[0]});
    bus(gpio_pkg::IDX_PORT1_DATA, 1'b0, 8'h00);
    chk("od_high_rd", 8'h21, q & 8'h21);
    bus(gpio_pkg::IDX_PIN_OPEN_DRAIN_CTRL, 1'b1, 8'h00);
    chk("od_off", 8'h03, {6'h0, p1_oe[0], p1_out[0]});
    chk("oe1", 8'h01, {3'h0, p1_oe});
    chk("out1", 8'h01, {3'h0, p1_out});
    ext_rst <= 1'b0;
    bus(gpio_pkg::IDX_PORT1_DATA, 1'b0, 8'h00);
    chk("rst_pin_rd", 8'h00, q & 8'h20);
    ext_rst <= 1'b1;
    bus(gpio_pkg::IDX_PORT5_PULLUP, 1'b1, 8'h3c);
    chk("pu5", 8'h3c, p5_pu);
    reset_seq();
    wrap_up();
  end
endmodule

`default_nettype wire
